// [rtl/flash_cmd_engine.sv]
// command decoder and flash sequencer of the serial programming port
`timescale 1ns/1ps
module flash_cmd_engine #(
  parameter int ProgCycles = (flash_cmd_pkg::ProgNs + flash_cmd_pkg::ClkNs - 1)
                             / flash_cmd_pkg::ClkNs
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire flash_cmd_pkg::rx_byte_t   rxByte,
  input  wire logic                      txReady,
  input  wire logic                      flashAccessMode,
  input  wire logic                      progIfMode,
  input  wire logic                      ctlUnlocked,
  input  wire logic                      fullRwProtectOpt,
  input  wire logic                      lowerHalfProtectOpt,
  input  wire logic                      mem64k,
  input  wire logic                      eraseStart,
  input  wire logic [11:0]               baudValue,
  input  wire logic [7:0]                flashRdata,
  output flash_cmd_pkg::tx_byte_t        txByte,
  output flash_cmd_pkg::flash_req_t      flashReq,
  output logic                           flashOpPending,
  output logic [7:0]                     testConfigReg
);
  import flash_cmd_pkg::*;

  localparam logic [16:0] ProgCnt = 17'(ProgCycles);

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  function automatic logic isProtected(input logic [15:0] a,
                                       input logic        full,
                                       input logic        lower,
                                       input logic [16:0] msize,
                                       input logic        wr);
    logic inMain;
    logic inLow;
    logic inPg3;
    inMain = {1'b0, a} < msize;
    inLow  = {1'b0, a} < (msize >> 1);
    inPg3  = wr && (a >= InfoBase) && (a[15:8] == InfoPg3[15:8])
             && (a[1:0] == InfoPg3[1:0]);
    isProtected = (full && (inMain || inPg3))
                  || (lower && (inLow || inPg3));
  endfunction

  state_t      state_r;
  logic [7:0]  cmd_r;
  logic [2:0]  argCnt_r;
  logic [15:0] addr_r;
  logic [16:0] size_r;
  logic [16:0] left_r;
  logic [16:0] timer_r;
  logic [15:0] crc_r;
  logic [7:0]  hold_r;
  logic [16:0] memSize;
  logic        rxv;
  logic [16:0] reqSize;
  logic [16:0] nextCrc;

  assign memSize = mem64k ? Size64k : Size32k;
  assign rxv     = rxByte.valid;

  always_comb
  begin
    reqSize = {1'b0, addr_r[7:0], rxByte.data};
    if (cmd_r == CmdMemWr || cmd_r == CmdMemRd)
    begin
      reqSize = {1'b0, size_r[7:0], rxByte.data};
      if (reqSize == 17'h00000 || reqSize > memSize)
        reqSize = memSize;
    end
    else
      reqSize = {9'h000, rxByte.data} + 17'h00001;
  end

  always_comb
  begin
    logic [15:0] c;
    c = crc_r ^ {flashRdata, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? ((c << 1) ^ CrcPoly) : (c << 1);
    nextCrc = {1'b0, c};
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r  <= StIdle;
      cmd_r    <= 8'h00;
      argCnt_r <= 3'h0;
      addr_r   <= 16'h0000;
      size_r   <= 17'h00000;
      left_r   <= 17'h00000;
      timer_r  <= 17'h00000;
      crc_r    <= CrcSeed;
      hold_r   <= 8'h00;
      txByte   <= '0;
      flashReq <= '0;
      testConfigReg <= TestRst;
    end
    else
    begin
      flashReq.rd    <= 1'b0;
      flashReq.prog  <= 1'b0;
      flashReq.regWr <= 1'b0;
      flashReq.regRd <= 1'b0;
      flashReq.ignoreLock <= 1'b1;
      if (txByte.valid && txReady)
        txByte.valid <= 1'b0;
      case (state_r)
        StIdle:
          if (rxv)
          begin
            cmd_r    <= rxByte.data;
            argCnt_r <= 3'h0;
            // every command starts its byte timer from zero
            timer_r  <= 17'h00000;
            if (rxByte.data == CmdBaudRd)
            begin
              txByte  <= '{valid: 1'b1, data: {4'h0, baudValue[11:8]}};
              hold_r  <= baudValue[7:0];
              state_r <= StOut2;
            end
            else if (rxByte.data == CmdTestRd)
            begin
              txByte  <= '{valid: 1'b1, data: testConfigReg};
              state_r <= StSend;
            end
            else if (rxByte.data == CmdTestWr)
              state_r <= StTest;
            else if (rxByte.data == CmdCrc)
            begin
              addr_r  <= 16'h0000;
              left_r  <= memSize;
              crc_r   <= CrcSeed;
              timer_r <= 17'h00000;
              state_r <= StCrc;
            end
            else if (rxByte.data == CmdRegWr || rxByte.data == CmdRegRd
                     || rxByte.data == CmdMemWr || rxByte.data == CmdMemRd)
              state_r <= StArgs;
          end
        StTest:
          if (rxv)
          begin
            testConfigReg <= rxByte.data;
            state_r       <= StIdle;
          end
        StArgs:
          if (rxv)
          begin
            argCnt_r <= argCnt_r + 3'h1;
            case (argCnt_r)
              3'h0: addr_r[15:8] <= rxByte.data;
              3'h1: addr_r[7:0]  <= rxByte.data;
              3'h2:
                if (cmd_r == CmdRegWr || cmd_r == CmdRegRd)
                begin
                  left_r <= reqSize;
                  state_r <= (cmd_r == CmdRegWr) ? StData : StRead;
                end
                else
                  size_r[7:0] <= rxByte.data;
              default:
              begin
                left_r  <= reqSize;
                state_r <= (cmd_r == CmdMemWr) ? StData : StRead;
              end
            endcase
          end
        StData:
          if (rxv)
          begin
            if (cmd_r == CmdRegWr)
            begin
              flashReq.regWr <= flashAccessMode;
              flashReq.addr  <= addr_r;
              flashReq.wdata <= rxByte.data;
              state_r        <= StSkip;
            end
            else if (flashAccessMode && ctlUnlocked
                     && !isProtected(addr_r, fullRwProtectOpt,
                                     lowerHalfProtectOpt, memSize, 1'b1))
            begin
              flashReq.prog  <= 1'b1;
              flashReq.addr  <= addr_r;
              flashReq.wdata <= rxByte.data;
              timer_r        <= ProgCnt;
              state_r        <= StWait;
            end
            else
              state_r <= StSkip;
          end
        StWait:
          if (timer_r <= 17'h00001)
            state_r <= StSkip;
          else
            timer_r <= timer_r - 17'h00001;
        StSkip:
        begin
          addr_r <= addr_r + 16'h0001;
          left_r <= left_r - 17'h00001;
          if (left_r == 17'h00001)
            state_r <= StIdle;
          else if (cmd_r == CmdRegWr || cmd_r == CmdMemWr)
            state_r <= StData;
          else
            state_r <= StRead;
        end
        StRead:
          if (!txByte.valid)
          begin
            flashReq.rd    <= (timer_r == 17'h00000);
            flashReq.regRd <= (timer_r == 17'h00000) && cmd_r == CmdRegRd;
            flashReq.addr  <= addr_r;
            if (timer_r == 17'(ReadCycles))
            begin
              timer_r <= 17'h00000;
              if (!flashAccessMode || (cmd_r == CmdMemRd
                  && isProtected(addr_r, fullRwProtectOpt,
                                 lowerHalfProtectOpt, memSize, 1'b0)))
                txByte <= '{valid: 1'b1, data: FillByte};
              else
                txByte <= '{valid: 1'b1, data: flashRdata};
              state_r <= StSkip;
            end
            else
              timer_r <= timer_r + 17'h00001;
          end
        StCrc:
        begin
          // one read strobe per byte, as for host reads
          flashReq.rd   <= (timer_r == 17'h00000);
          flashReq.addr <= addr_r;
          if (timer_r == 17'(ReadCycles))
          begin
            timer_r <= 17'h00000;
            crc_r   <= nextCrc[15:0];
            addr_r  <= addr_r + 16'h0001;
            left_r  <= left_r - 17'h00001;
            if (left_r == 17'h00001)
            begin
              txByte <= '{valid: 1'b1,
                          data: progIfMode ? nextCrc[15:8] : CrcFill[15:8]};
              hold_r <= progIfMode ? nextCrc[7:0] : CrcFill[7:0];
              state_r <= StOut2;
            end
          end
          else
            timer_r <= timer_r + 17'h00001;
        end
        StOut2:
          if (txByte.valid && txReady)
          begin
            txByte  <= '{valid: 1'b1, data: hold_r};
            state_r <= StSend;
          end
        StSend:
          if (!txByte.valid || txReady)
            state_r <= StIdle;
        default: state_r <= StIdle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pending flag
  // ----------------------------------------------------------------
  logic [16:0] erase_r;
  // busy while program or erase runs
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      flashOpPending <= 1'b0;
      erase_r        <= 17'h00000;
    end
    else
    begin
      if (eraseStart)
        erase_r <= ProgCnt;
      else if (erase_r != 17'h00000)
        erase_r <= erase_r - 17'h00001;
      flashOpPending <= (state_r == StWait && timer_r > 17'h00001)
                        || flashReq.prog || eraseStart
                        || erase_r > 17'h00001;
    end
  end
endmodule // flash_cmd_engine

// [rtl/flash_cmd_pkg.sv]
// constants and carrier types of the serial flash command engine
package flash_cmd_pkg;
  localparam logic [7:0] CmdRegWr  = 8'h08;
  localparam logic [7:0] CmdRegRd  = 8'h09;
  localparam logic [7:0] CmdMemWr  = 8'h0a;
  localparam logic [7:0] CmdMemRd  = 8'h0b;
  localparam logic [7:0] CmdCrc    = 8'h0e;
  localparam logic [7:0] CmdBaudRd = 8'h1b;
  localparam logic [7:0] CmdTestWr = 8'hf0;
  localparam logic [7:0] CmdTestRd = 8'hf1;
  localparam logic [7:0] FillByte  = 8'hff;
  localparam logic [15:0] CrcFill  = 16'hffff;
  localparam logic [15:0] CrcSeed  = 16'hffff;
  localparam logic [15:0] CrcPoly  = 16'h1021;
  localparam logic [7:0] TestRst   = 8'h00;
  localparam logic [16:0] Size32k  = 17'h08000;
  localparam logic [16:0] Size64k  = 17'h10000;
  localparam logic [15:0] InfoBase = 16'hfe00;
  localparam logic [15:0] InfoPg3  = 16'hfe03;
  localparam int          ReadCycles = 2;
  // program and erase time and clock period in nanoseconds
  localparam int          ProgNs   = 65000;
  localparam int          ClkNs    = 25;

  // byte received from the host
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_byte_t;

  // byte for the host
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tx_byte_t;

  // request to the flash controller
  typedef struct packed {
    logic        rd;
    logic        prog;
    logic        regWr;
    logic        regRd;
    logic        ignoreLock;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } flash_req_t;

  typedef enum logic [9:0] {
    StIdle  = 10'h001,
    StArgs  = 10'h002,
    StData  = 10'h004,
    StWait  = 10'h008,
    StSend  = 10'h010,
    StCrc   = 10'h020,
    StTest  = 10'h040,
    StRead  = 10'h080,
    StSkip  = 10'h100,
    StOut2  = 10'h200
  } state_t;
endpackage

// [sim/flash_cmd_checker.sv]
// port assertions of the flash command engine
`timescale 1ns/1ps
module flash_cmd_checker (
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire flash_cmd_pkg::rx_byte_t  rxByte,
  input wire logic                     txReady,
  input wire logic                     ctlUnlocked,
  input wire logic                     fullRwProtectOpt,
  input wire flash_cmd_pkg::tx_byte_t  txByte,
  input wire flash_cmd_pkg::flash_req_t flashReq,
  input wire logic                     flashOpPending,
  input wire logic [7:0]               testConfigReg
);
  import flash_cmd_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_busy;
    flashOpPending [*3] ##[1:3] !flashOpPending;
  endsequence
  a_test_load: assert property ($past(nrst) && $changed(testConfigReg)
    |-> $past(rxByte.valid) && testConfigReg == $past(rxByte.data))
    else $error("test register changed without a data byte");
  a_tx_hold: assert property (txByte.valid && !txReady
    |=> txByte.valid && $stable(txByte.data))
    else $error("answer byte dropped before acceptance");
  a_prog_pulse: assert property (flashReq.prog |=> !flashReq.prog)
    else $error("program strobe longer than one cycle");
  a_rd_pulse: assert property (flashReq.rd |=> !flashReq.rd)
    else $error("read strobe longer than one cycle");
  a_prog_busy: assert property (flashReq.prog |-> ##[0:1] flashOpPending)
    else $error("pending flag not raised by program");
  a_busy_len: assert property ($rose(flashOpPending) |-> s_busy)
    else $error("pending flag length wrong");
  a_no_locked: assert property (flashReq.prog |-> $past(ctlUnlocked))
    else $error("program while controller locked");
  a_full_prot: assert property (flashReq.prog && fullRwProtectOpt
    |-> flashReq.addr[15:8] == 8'hfe)
    else $error("program into protected main array");
  a_ignore_lock: assert property ($past(nrst) && $past(nrst, 2)
    |-> flashReq.ignoreLock)
    else $error("sector lock not bypassed");
endmodule // flash_cmd_checker
bind flash_cmd_engine flash_cmd_checker i_flash_cmd_checker (
  .clk(clk), .nrst(nrst), .rxByte(rxByte), .txReady(txReady),
  .ctlUnlocked(ctlUnlocked), .fullRwProtectOpt(fullRwProtectOpt),
  .txByte(txByte), .flashReq(flashReq), .flashOpPending(flashOpPending),
  .testConfigReg(testConfigReg));

// [sim/flash_model.sv]
// behavioural flash array behind the controller
`timescale 1ns/1ps
module flash_model (
  input  wire logic                      clk,
  input  wire flash_cmd_pkg::flash_req_t flashReq,
  output logic [7:0]                     flashRdata
);
  import flash_cmd_pkg::*;
  logic [7:0] mem [int];
  int         hold = 0;
  initial flashRdata = 8'h5a;
  always @(posedge clk)
  begin
    if (flashReq.rd || flashReq.regRd)
    begin
      flashRdata <= mem.exists(flashReq.addr) ? mem[flashReq.addr] : FillByte;
      hold <= 2;
    end
    else if (hold > 0)
      hold <= hold - 1;
    else
      flashRdata <= ~flashRdata;
    if (flashReq.prog)
      mem[flashReq.addr] = flashReq.wdata;
  end
endmodule // flash_model

// [sim/testbench.sv]
// self-checking bench of the flash command engine
`timescale 1ns/1ps
module testbench;
  import flash_cmd_pkg::*;
  localparam int Prog = 4;
  logic        clk;
  logic        nrst;
  rx_byte_t    rxByte;
  logic        txReady;
  logic        flashAccessMode;
  logic        progIfMode;
  logic        ctlUnlocked;
  logic        fullRwProtectOpt;
  logic [11:0] baudValue;
  logic [7:0]  flashRdata;
  tx_byte_t    txByte;
  flash_req_t  flashReq;
  logic        flashOpPending;
  logic [7:0]  testConfigReg;
  logic [15:0] lfsr = 16'd11462;
  logic [7:0]  d;
  logic        eraseStart;
  int          regWrs = 0;
  logic [7:0]  regWrData;
  int          refMem [int];
  int          badCount = 0;
  int          compares = 0;
  int          cycles = 0;

  flash_cmd_engine #(.ProgCycles(Prog)) i_flash_cmd_engine (
    .clk(clk), .nrst(nrst), .rxByte(rxByte), .txReady(txReady),
    .flashAccessMode(flashAccessMode), .progIfMode(progIfMode),
    .ctlUnlocked(ctlUnlocked), .fullRwProtectOpt(fullRwProtectOpt),
    .lowerHalfProtectOpt(1'b0), .mem64k(1'b0), .eraseStart(eraseStart),
    .baudValue(baudValue), .flashRdata(flashRdata), .txByte(txByte),
    .flashReq(flashReq), .flashOpPending(flashOpPending),
    .testConfigReg(testConfigReg));
  flash_model i_flash_model (.clk(clk), .flashReq(flashReq),
    .flashRdata(flashRdata));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [7:0] lf();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rxByte <= '{valid: 1'b1, data: b};
    @(posedge clk);
    rxByte.valid <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] a,
                     input logic [15:0] s);
    send(c);
    send(a[15:8]);
    send(a[7:0]);
    send(s[15:8]);
    send(s[7:0]);
  endtask

  // wait for a byte, stall, then accept it
  task automatic get(input logic [7:0] exp, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (txByte.valid !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    repeat (lf() % 3) @(negedge clk);
    check(16'(txByte.valid), 16'h0001);
    check(16'(txByte.data), 16'(exp));
    @(posedge clk) txReady <= 1'b1;
    @(posedge clk) txReady <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input int n);
    cmd(CmdMemWr, a, 16'(n));
    for (int i = 0; i < n; i++)
    begin
      d = lf();
      if (ctlUnlocked && (!fullRwProtectOpt || a[15:8] == 8'hfe))
        refMem[a + i] = d;
      send(d);
      repeat (Prog + 4) @(posedge clk);
    end
  endtask

  task automatic rd(input logic [15:0] a, input int n);
    cmd(CmdMemRd, a, 16'(n));
    for (int i = 0; i < n; i++)
      get(fullRwProtectOpt ? FillByte : refMem.exists(a + i)
          ? 8'(refMem[a + i]) : FillByte, 40);
  endtask

  // register write strobes seen by the controller
  always @(posedge clk)
  begin
    if (flashReq.regWr)
    begin
      regWrs++;
      regWrData = flashReq.wdata;
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      badCount++;
      give_verdict();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    rxByte = '0;
    txReady = 1'b0;
    flashAccessMode = 1'b1;
    progIfMode = 1'b1;
    ctlUnlocked = 1'b1;
    fullRwProtectOpt = 1'b0;
    eraseStart = 1'b0;
    d = lf();
    baudValue = {d[3:0], lf()};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check(16'(testConfigReg), 16'(TestRst));
    d = lf();
    send(CmdTestWr);
    send(d);
    send(CmdTestRd);
    get(d, 40);
    send(CmdBaudRd);
    get({4'h0, baudValue[11:8]}, 40);
    get(baudValue[7:0], 40);
    wr(16'h1230, 3);
    rd(16'h1230, 3);
    ctlUnlocked <= 1'b0;
    wr(16'h1231, 2);
    ctlUnlocked <= 1'b1;
    rd(16'h1230, 3);
    fullRwProtectOpt <= 1'b1;
    wr(16'hfe00, 1);
    wr(16'h1230, 1);
    rd(16'h1230, 2);
    fullRwProtectOpt <= 1'b0;
    rd(16'h1230, 1);
    rd(16'hfe00, 1);
    d = lf();
    send(CmdRegWr);
    send(8'h0f);
    send(8'h22);
    send(8'h00);
    send(d);
    repeat (2) @(posedge clk);
    check(16'(regWrs), 16'h0001);
    check(16'(regWrData), 16'(d));
    @(posedge clk) eraseStart <= 1'b1;
    @(posedge clk) eraseStart <= 1'b0;
    @(negedge clk);
    check(16'(flashOpPending), 16'h0001);
    repeat (Prog + 2) @(posedge clk);
    @(negedge clk);
    check(16'(flashOpPending), 16'h0000);
    flashAccessMode <= 1'b0;
    send(CmdRegWr);
    send(8'h0f);
    send(8'h22);
    send(8'h00);
    send(lf());
    repeat (2) @(posedge clk);
    check(16'(regWrs), 16'h0001);
    send(CmdRegRd);
    send(8'h0f);
    send(lf());
    send(8'h01);
    get(FillByte, 40);
    get(FillByte, 40);
    progIfMode <= 1'b0;
    send(CmdCrc);
    get(8'hff, 110000);
    get(8'hff, 40);
    give_verdict();
  end
endmodule // testbench
